// ===== design/cmmd_pkg.sv
package cmmd_pkg;
  // ==========================================================
  // memory map
  localparam logic [19:0] FLASH_LAST = 20'h07FFF;
  localparam logic [19:0] VEC_BASE   = 20'h00000;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_BASE = 20'h00080;
  localparam logic [19:0] OPT_BASE   = 20'h000C0;
  localparam logic [19:0] SWAP_OFS   = 20'h01000;
  localparam logic [19:0] SFR2_FIRST = 20'hF0000;
  localparam logic [19:0] SFR2_LAST  = 20'hF07FF;
  localparam logic [19:0] MIR_FIRST  = 20'hF2000;
  localparam logic [19:0] MIR_LAST   = 20'hF7FFF;
  localparam logic [19:0] RAM_FIRST  = 20'hFE900;
  localparam logic [19:0] RAM_LAST   = 20'hFFEFF;
  localparam logic [19:0] GPR_FIRST  = 20'hFFEE0;
  localparam logic [19:0] SFR_FIRST  = 20'hFFF00;
  localparam logic [15:0] MSEL_OFS   = 16'hFFFE;
  localparam logic [3:0]  MSEL_PAGE  = 4'hF;
  localparam int          BLK_LSB    = 10;
  localparam int          BLK_MSB    = 14;
  localparam logic [4:0]  BC0_LAST   = 5'h03;
  // ==========================================================
  // configuration bytes and registers
  localparam int          OPT_N      = 4;
  localparam int          ID_N       = 10;
  localparam int          CFG_N      = 14;
  localparam logic [3:0]  CFG_LAST   = 4'hD;
  localparam logic [7:0]  MSEL_RST   = 8'h00;
  localparam logic [7:0]  MSEL_MASK  = 8'h01;
  localparam int          MSEL_BIT   = 0;
  localparam logic        MIR_LOW64K = 1'b0;
  // ==========================================================
  // carriers
  typedef logic [19:0] cmmd_addr_t;
  typedef struct packed {
    logic       valid;
    logic       fetch;
    logic       write;
    cmmd_addr_t addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cmmd_cpu_req_t;
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] rdata;
  } cmmd_cpu_rsp_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [14:0] addr;
    logic [4:0]  block;
    logic [7:0]  wdata;
  } cmmd_flash_req_t;
  typedef struct packed {
    logic       ram_sel;
    logic       sfr_sel;
    logic       sfr2_sel;
    logic       we;
    logic       fetch;
    cmmd_addr_t addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cmmd_bus_req_t;
  typedef struct packed {
    logic       valid;
    cmmd_addr_t target;
  } cmmd_vec_rsp_t;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_FLASH, SRC_RAM, SRC_SFR, SRC_SFR2, SRC_MSEL
  } cmmd_src_t;
  typedef enum {S_LOAD, S_LOAD_END, S_IDLE, S_VLO, S_VHI, S_VEND} cmmd_state_t;
endpackage

// ===== design/cmmd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module cmmd_decoder (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire cmmd_pkg::cmmd_cpu_req_t  cpu_req,
  output logic                          cpu_ready,
  output cmmd_pkg::cmmd_cpu_rsp_t       cpu_rsp,
  input  wire logic                     vec_req,
  input  wire logic                     vec_table_call_instruction,
  input  wire logic [5:0]               vec_idx,
  output logic                          vec_ready,
  output cmmd_pkg::cmmd_vec_rsp_t       vec_rsp,
  input  wire logic                     boot_swap,
  input  wire logic                     boot_wr_protect,
  input  wire logic                     parity_dis_we,
  input  wire logic                     parity_dis_wdata,
  output logic                          ram_parity_reset_disable,
  output cmmd_pkg::cmmd_flash_req_t     flash_req,
  input  wire logic [7:0]               flash_rdata,
  output cmmd_pkg::cmmd_bus_req_t       bus_req,
  input  wire logic [7:0]               ram_rdata,
  input  wire logic [7:0]               sfr_rdata,
  input  wire logic [7:0]               sfr2_rdata,
  output logic [3:0][7:0]               opt_bytes,
  output logic [9:0][7:0]               debug_id,
  output logic                          cfg_loaded,
  output cmmd_pkg::cmmd_addr_t          reset_pc
);
  import cmmd_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic in_rng(input cmmd_addr_t a,
                                  input cmmd_addr_t lo,
                                  input cmmd_addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [14:0] ent_addr(input cmmd_addr_t base,
                                           input logic       swap,
                                           input logic [6:0] ofs);
    cmmd_addr_t s;
    s = base + (swap ? SWAP_OFS : 20'h00000) + {13'h0000, ofs};
    return s[14:0];
  endfunction

  // ==========================================================
  // state
  cmmd_state_t   st_q;
  logic [3:0]    ld_cnt_q, ld_idx_q;
  logic          ld_pend_q, vk_table_call_instruction_q, boot_vec_q, p1_v_q, p1_err_q, loaded_q, prdis_q;
  logic [7:0]    cfg_q [CFG_N];
  logic [5:0]    vk_idx_q;
  logic [7:0]    tgt_lo_q, msel_q;
  cmmd_src_t     p1_src_q;
  cmmd_cpu_rsp_t rsp_q;
  cmmd_vec_rsp_t vec_q;
  cmmd_addr_t    reset_pc_q;

  // ==========================================================
  // cpu decode
  cmmd_addr_t a;
  logic       hit_flash, hit_sfr, hit_sfr2, hit_ram, hit_gpr;
  logic       hit_msel, hit_mir, bc0, err, take;
  cmmd_src_t  src;

  always_comb begin
    a         = cpu_req.addr;
    hit_flash = a <= FLASH_LAST;
    hit_sfr   = a >= SFR_FIRST;
    hit_msel  = a == {MSEL_PAGE, MSEL_OFS};
    hit_sfr2  = in_rng(a, SFR2_FIRST, SFR2_LAST);
    hit_ram   = in_rng(a, RAM_FIRST, RAM_LAST);
    hit_gpr   = in_rng(a, GPR_FIRST, RAM_LAST);
    hit_mir   = in_rng(a, MIR_FIRST, MIR_LAST)
                && !hit_sfr && !hit_sfr2 && !hit_ram
                && (msel_q[MSEL_BIT] == MIR_LOW64K);
    bc0       = a[BLK_MSB:BLK_LSB] <= BC0_LAST;
    err       = 1'b0;
    src       = SRC_NONE;
    if (hit_flash) begin
      src = SRC_FLASH;
      err = cpu_req.write && bc0 && boot_wr_protect;
    end else if (hit_mir) begin
      src = SRC_FLASH;
      err = cpu_req.fetch || cpu_req.write;
    end else if (hit_msel) begin
      src = SRC_MSEL;
      err = cpu_req.fetch;
    end else if (hit_sfr) begin
      src = SRC_SFR;
      err = cpu_req.fetch;
    end else if (hit_sfr2) begin
      src = SRC_SFR2;
      err = cpu_req.fetch;
    end else if (hit_ram) begin
      src = SRC_RAM;
      err = cpu_req.fetch && hit_gpr;
    end else begin
      err = 1'b1;
    end
  end

  assign cpu_ready = (st_q == S_IDLE) && !vec_req;
  assign vec_ready = st_q == S_IDLE;
  assign take      = cpu_req.valid && cpu_ready;

  // ==========================================================
  // memory ports
  always_comb begin
    flash_req       = '0;
    flash_req.wdata = cpu_req.wdata;
    unique case (st_q)
      S_LOAD:
        flash_req.addr = ent_addr(OPT_BASE, boot_swap,
                                  {3'h0, ld_cnt_q});
      S_VLO:
        flash_req.addr = ent_addr(vk_table_call_instruction_q ? TABLE_CALL_INSTRUCTION_BASE : VEC_BASE,
                                  boot_swap, {vk_idx_q, 1'b0});
      S_VHI:
        flash_req.addr = ent_addr(vk_table_call_instruction_q ? TABLE_CALL_INSTRUCTION_BASE : VEC_BASE,
                                  boot_swap, {vk_idx_q, 1'b1});
      default:
        flash_req.addr = a[14:0];
    endcase
    flash_req.req   = (st_q == S_LOAD) || (st_q == S_VLO) || (st_q == S_VHI)
                      || (take && (src == SRC_FLASH) && !err);
    flash_req.we    = take && hit_flash && cpu_req.write && !err;
    flash_req.block = flash_req.addr[BLK_MSB:BLK_LSB];
  end

  always_comb begin
    bus_req          = '0;
    bus_req.addr     = a;
    bus_req.wdata    = cpu_req.wdata;
    bus_req.wmask    = cpu_req.wmask;
    bus_req.fetch    = cpu_req.fetch;
    bus_req.we       = cpu_req.write;
    bus_req.ram_sel  = take && !err && (src == SRC_RAM);
    bus_req.sfr_sel  = take && !err && (src == SRC_SFR);
    bus_req.sfr2_sel = take && !err && (src == SRC_SFR2);
  end

  // ==========================================================
  // sequencer: config load, reset vector, vector reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q       <= S_LOAD;
      ld_cnt_q   <= 4'h0;
      vk_table_call_instruction_q <= 1'b0;
      vk_idx_q   <= 6'h00;
      boot_vec_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_LOAD: begin
          ld_cnt_q <= ld_cnt_q + 4'h1;
          if (ld_cnt_q == CFG_LAST) begin
            st_q <= S_LOAD_END;
          end
        end
        S_LOAD_END: begin
          vk_table_call_instruction_q <= 1'b0;
          vk_idx_q   <= 6'h00;
          boot_vec_q <= 1'b1;
          st_q       <= S_VLO;
        end
        S_IDLE: begin
          if (vec_req) begin
            vk_table_call_instruction_q <= vec_table_call_instruction;
            vk_idx_q   <= vec_idx;
            boot_vec_q <= 1'b0;
            st_q       <= S_VLO;
          end
        end
        S_VLO:   st_q <= S_VHI;
        S_VHI:   st_q <= S_VEND;
        S_VEND:  st_q <= S_IDLE;
      endcase
    end
  end

  // config bytes land one cycle after their address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_pend_q <= 1'b0;
      ld_idx_q  <= 4'h0;
      for (int i = 0; i < CFG_N; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else begin
      ld_pend_q <= st_q == S_LOAD;
      ld_idx_q  <= ld_cnt_q;
      if (ld_pend_q) begin
        cfg_q[ld_idx_q] <= flash_rdata;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < OPT_N; i++) begin
      opt_bytes[i] = cfg_q[i];
    end
    for (int i = 0; i < ID_N; i++) begin
      debug_id[i] = cfg_q[OPT_N + i];
    end
  end

  // vector assembly, low byte first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tgt_lo_q   <= 8'h00;
      vec_q      <= '0;
      reset_pc_q <= VEC_BASE;
      loaded_q   <= 1'b0;
    end else begin
      vec_q.valid <= 1'b0;
      if (st_q == S_VHI) begin
        tgt_lo_q <= flash_rdata;
      end
      if (st_q == S_VEND) begin
        if (boot_vec_q) begin
          reset_pc_q <= {4'h0, flash_rdata, tgt_lo_q};
          loaded_q   <= 1'b1;
        end else begin
          vec_q.valid  <= 1'b1;
          vec_q.target <= {4'h0, flash_rdata, tgt_lo_q};
        end
      end
    end
  end

  // ==========================================================
  // mirror select and parity control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msel_q <= MSEL_RST;
    end else if (take && hit_msel && cpu_req.write) begin
      msel_q <= ((msel_q & ~cpu_req.wmask)
                 | (cpu_req.wdata & cpu_req.wmask)) & MSEL_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdis_q <= 1'b0;
    end else if (parity_dis_we) begin
      prdis_q <= parity_dis_wdata;
    end
  end

  // ==========================================================
  // cpu answer, two cycles after the request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_v_q   <= 1'b0;
      p1_err_q <= 1'b0;
      p1_src_q <= SRC_NONE;
      rsp_q    <= '0;
    end else begin
      p1_v_q      <= take;
      p1_err_q    <= err;
      p1_src_q    <= src;
      rsp_q.valid <= p1_v_q;
      rsp_q.err   <= p1_err_q;
      if (p1_v_q) begin
        if (p1_err_q) begin
          rsp_q.rdata <= 8'h00;
        end else begin
          unique case (p1_src_q)
            SRC_FLASH: rsp_q.rdata <= flash_rdata;
            SRC_RAM:   rsp_q.rdata <= ram_rdata;
            SRC_SFR:   rsp_q.rdata <= sfr_rdata;
            SRC_SFR2:  rsp_q.rdata <= sfr2_rdata;
            SRC_MSEL:  rsp_q.rdata <= msel_q & MSEL_MASK;
            default:   rsp_q.rdata <= 8'h00;
          endcase
        end
      end
    end
  end

  assign cpu_rsp                  = rsp_q;
  assign vec_rsp                  = vec_q;
  assign reset_pc                 = reset_pc_q;
  assign cfg_loaded               = loaded_q;
  assign ram_parity_reset_disable = prdis_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_mir_read;
    take && hit_mir && !cpu_req.fetch && !cpu_req.write
      |-> flash_req.req && (flash_req.addr == cpu_req.addr[14:0])
          ##2 cpu_rsp.valid && !cpu_rsp.err;
  endproperty
  a_mir_read: assert property (p_mir_read)
    else $error("mirror read not routed to flash");
  property p_mir_fetch;
    take && cpu_req.fetch && in_rng(cpu_req.addr, MIR_FIRST, MIR_LAST)
      |-> !flash_req.req ##2 cpu_rsp.valid && cpu_rsp.err;
  endproperty
  a_mir_fetch: assert property (p_mir_fetch)
    else $error("fetch from mirror not refused");
  property p_ram_fetch;
    take && cpu_req.fetch && in_rng(cpu_req.addr, RAM_FIRST, RAM_LAST)
      |-> ##2 cpu_rsp.err == in_rng($past(cpu_req.addr, 2), GPR_FIRST, RAM_LAST);
  endproperty
  a_ram_fetch: assert property (p_ram_fetch)
    else $error("ram fetch permission wrong");
  property p_sfr_prio;
    take && (in_rng(cpu_req.addr, RAM_FIRST, 20'hFFFFF)
             || in_rng(cpu_req.addr, SFR2_FIRST, SFR2_LAST))
      |-> !flash_req.req;
  endproperty
  a_sfr_prio: assert property (p_sfr_prio)
    else $error("mirror overlays another region");
  property p_block;
    flash_req.req |-> flash_req.block == flash_req.addr[14:10];
  endproperty
  a_block: assert property (p_block)
    else $error("block number mismatch");
  property p_msel_rst;
    @(posedge sys_clk) disable iff (1'b0)
      rst |=> (msel_q == 8'h00) && !ram_parity_reset_disable;
  endproperty
  a_msel_rst: assert property (p_msel_rst)
    else $error("reset values wrong");
  property p_msel_hi;
    cpu_rsp.valid && $past(p1_src_q) == SRC_MSEL |-> cpu_rsp.rdata[7:1] == 7'h00;
  endproperty
  a_msel_hi: assert property (p_msel_hi)
    else $error("mirror select upper bits not zero");
  property p_bc0;
    take && cpu_req.write && (cpu_req.addr < 20'h01000) && boot_wr_protect
      |-> !flash_req.we ##2 cpu_rsp.err;
  endproperty
  a_bc0: assert property (p_bc0)
    else $error("boot cluster 0 write not blocked");
  property p_vec;
    vec_req && vec_ready
      |-> ##1 flash_req.req && !flash_req.addr[0]
          ##1 flash_req.req && flash_req.addr[0]
          ##2 vec_rsp.valid && vec_rsp.target[19:16] == 4'h0;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector read sequence wrong");
  property p_reset_vec;
    st_q == S_LOAD_END
      |-> ##1 flash_req.addr == (boot_swap ? 15'h1000 : 15'h0000)
          ##3 cfg_loaded;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector not at base");
  c_mir: cover property (take && hit_mir ##2 cpu_rsp.valid);
  c_vec: cover property (vec_req && vec_ready && vec_table_call_instruction ##4 vec_rsp.valid);
  c_msel: cover property (take && hit_msel && cpu_req.write);
  c_boot: cover property ($rose(cfg_loaded));
endmodule
`default_nettype wire

// ===== test/cmmd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// flash, ram and sfr read model, data one cycle after select
module cmmd_mem_model (
  input  wire logic                      sys_clk,
  input  wire cmmd_pkg::cmmd_flash_req_t flash_req,
  input  wire cmmd_pkg::cmmd_bus_req_t   bus_req,
  output logic [7:0]                     flash_rdata,
  output logic [7:0]                     ram_rdata,
  output logic [7:0]                     sfr_rdata,
  output logic [7:0]                     sfr2_rdata
);
  import cmmd_pkg::*;
  initial {flash_rdata, ram_rdata, sfr_rdata, sfr2_rdata} = 32'h0;
  // released lines toggle so stale data never matches
  // odd bytes keep bit 7 clear so every table entry points below 08000H
  always @(posedge sys_clk) begin
    flash_rdata <= (flash_req.req && !flash_req.we) ?
                   {flash_req.addr[7] & ~flash_req.addr[0], flash_req.addr[6:0]}
                   ^ {1'b0, flash_req.addr[14:8]} : ~flash_rdata;
    ram_rdata   <= (bus_req.ram_sel && !bus_req.we) ? bus_req.addr[7:0] ^ 8'h5A : ~ram_rdata;
    sfr_rdata   <= (bus_req.sfr_sel && !bus_req.we) ? bus_req.addr[7:0] ^ 8'hA5 : ~sfr_rdata;
    sfr2_rdata  <= (bus_req.sfr2_sel && !bus_req.we) ? bus_req.addr[7:0] ^ 8'h3C : ~sfr2_rdata;
  end
endmodule
`default_nettype wire

// ===== test/cmmd_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cmmd_decoder_bench;
  import cmmd_pkg::*;
  logic            sys_clk, rst, cpu_ready, vec_req, vec_table_call_instruction, vec_ready, boot_swap;
  logic            boot_wr_protect, parity_dis_we, parity_dis_wdata, cfg_loaded;
  logic            ram_parity_reset_disable;
  logic [5:0]      vec_idx;
  logic [7:0]      flash_rdata, ram_rdata, sfr_rdata, sfr2_rdata;
  logic [3:0][7:0] opt_bytes;
  logic [9:0][7:0] debug_id;
  cmmd_addr_t      reset_pc, a;
  cmmd_cpu_req_t   cpu_req;
  cmmd_cpu_rsp_t   cpu_rsp;
  cmmd_vec_rsp_t   vec_rsp;
  cmmd_flash_req_t flash_req;
  cmmd_bus_req_t   bus_req;
  int              mismatches, n_tests, cycles;
  logic [9:0]      exp_cpu[$];
  cmmd_addr_t      exp_vec[$];

  cmmd_decoder u_cmmd_decoder (.sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req),
    .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp), .vec_req(vec_req), .vec_table_call_instruction(vec_table_call_instruction),
    .vec_idx(vec_idx), .vec_ready(vec_ready), .vec_rsp(vec_rsp), .boot_swap(boot_swap),
    .boot_wr_protect(boot_wr_protect), .parity_dis_we(parity_dis_we),
    .parity_dis_wdata(parity_dis_wdata), .ram_parity_reset_disable(ram_parity_reset_disable),
    .flash_req(flash_req), .flash_rdata(flash_rdata), .bus_req(bus_req),
    .ram_rdata(ram_rdata), .sfr_rdata(sfr_rdata), .sfr2_rdata(sfr2_rdata),
    .opt_bytes(opt_bytes), .debug_id(debug_id), .cfg_loaded(cfg_loaded), .reset_pc(reset_pc));
  cmmd_mem_model u_cmmd_mem_model (.sys_clk(sys_clk), .flash_req(flash_req),
    .bus_req(bus_req), .flash_rdata(flash_rdata), .ram_rdata(ram_rdata),
    .sfr_rdata(sfr_rdata), .sfr2_rdata(sfr2_rdata));

  // ==========================================================
  // helpers
  function automatic logic [7:0] fl(input cmmd_addr_t x);
    return {x[7] & ~x[0], x[6:0]} ^ {1'b0, x[14:8]};
  endfunction
  function automatic logic [7:0] rm(input cmmd_addr_t x);
    return x[7:0] ^ 8'h5A;
  endfunction
  task automatic chk(input string what, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // held request until ready seen, then taken on the next rising edge
  task automatic cpu(input logic f, w, input cmmd_addr_t x, input logic [7:0] d, m,
                     input logic e, input logic [7:0] v);
    int n;
    @(negedge sys_clk);
    cpu_req = '{1'b1, f, w, x, d, m};
    n = 0;
    #1;
    while (cpu_ready !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      #1;
      n++;
    end
    if (!e && (x < 20'h08000 || (x >= 20'hF2000 && x <= 20'hF7FFF))) begin
      chk("flash_req.block", {15'h0, x[14:10]}, {15'h0, flash_req.block});
      chk("flash_req.addr", {5'h0, x[14:0]}, {5'h0, flash_req.addr});
    end
    exp_cpu.push_back({!w | e, e, e ? 8'h00 : v});
    @(posedge sys_clk);
  endtask
  task automatic rd(input cmmd_addr_t x, input logic [7:0] v, input logic e);
    cpu(1'b0, 1'b0, x, 8'h00, 8'h00, e, v);
  endtask
  task automatic fe(input cmmd_addr_t x, input logic [7:0] v, input logic e);
    cpu(1'b1, 1'b0, x, 8'h00, 8'h00, e, v);
  endtask
  task automatic wr(input cmmd_addr_t x, input logic [7:0] d, m, input logic e);
    cpu(1'b0, 1'b1, x, d, m, e, 8'h00);
  endtask
  task automatic idle();
    @(negedge sys_clk);
    cpu_req.valid = 1'b0;
  endtask
  task automatic vec(input logic c, input logic [5:0] i);
    cmmd_addr_t x;
    int n;
    x = (c ? 20'h00080 : 20'h0) + (boot_swap ? 20'h01000 : 20'h0) + {13'h0, i, 1'b0};
    @(negedge sys_clk);
    vec_req = 1'b1;
    vec_table_call_instruction = c;
    vec_idx = i;
    n = 0;
    #1;
    while (vec_ready !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      #1;
      n++;
    end
    exp_vec.push_back({4'h0, fl(x + 20'h1), fl(x)});
    @(posedge sys_clk);
    @(negedge sys_clk);
    vec_req = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic sw);
    cmmd_addr_t o;
    int n;
    o = sw ? 20'h01000 : 20'h0;
    @(negedge sys_clk);
    rst = 1'b1;
    boot_swap = sw;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    n = 0;
    while (cfg_loaded !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    for (int i = 0; i < 4; i++)
      chk("opt_bytes", fl(o + 20'h000C0 + 20'(i)), opt_bytes[i]);
    for (int i = 0; i < 10; i++)
      chk("debug_id", fl(o + 20'h000C4 + 20'(i)), debug_id[i]);
    chk("reset_pc", {4'h0, fl(o + 20'h1), fl(o)}, reset_pc);
    chk("parity_disable", 0, ram_parity_reset_disable);
    $display("reset and configuration test done");
  endtask

  // ==========================================================
  // clock, timeout and result monitor
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("timeout reached");
      complete_run();
    end
  end
  always @(negedge sys_clk) begin
    logic [9:0] c;
    cmmd_addr_t t;
    if (cpu_rsp.valid === 1'b1) begin
      c = (exp_cpu.size() > 0) ? exp_cpu.pop_front() : 10'h3FF;
      chk("cpu_rsp.err", {19'h0, c[8]}, {19'h0, cpu_rsp.err});
      if (c[9])
        chk("cpu_rsp.rdata", {12'h0, c[7:0]}, {12'h0, cpu_rsp.rdata});
    end
    if (vec_rsp.valid === 1'b1) begin
      t = (exp_vec.size() > 0) ? exp_vec.pop_front() : 20'hFFFFF;
      chk("vec_rsp.target", t, vec_rsp.target);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    cmmd_addr_t fa[6] = '{20'h00000, 20'h0007F, 20'h000BF, 20'h003FF, 20'h00400, 20'h07FFF};
    void'($urandom(32'hF257B474));
    {rst, vec_req, vec_table_call_instruction, boot_swap, boot_wr_protect} = 5'h10;
    {parity_dis_we, parity_dis_wdata, vec_idx} = 8'h00;
    cpu_req = '0;
    do_reset(1'b0);
    foreach (fa[i]) rd(fa[i], fl(fa[i]), 1'b0);
    repeat (8) begin
      a = 20'($urandom_range(32'h7FFF));
      rd(a, fl(a), 1'b0);
      a = 20'hF2000 + 20'($urandom_range(32'h5FFF));
      rd(a, fl(a), 1'b0);
    end
    rd(20'hF7FFF, fl(20'hF7FFF), 1'b0);
    fe(20'hF2000, 8'h00, 1'b1);
    wr(20'hF3000, 8'h5A, 8'hFF, 1'b1);
    rd(20'hF1FFF, 8'h00, 1'b1);
    rd(20'hF0010, 8'h10 ^ 8'h3C, 1'b0);
    rd(20'hFE900, rm(20'hFE900), 1'b0);
    rd(20'hFFF10, 8'h10 ^ 8'hA5, 1'b0);
    fe(20'hFFF10, 8'h00, 1'b1);
    fe(20'hFE900, rm(20'hFE900), 1'b0);
    fe(20'hFFEDF, rm(20'hFFEDF), 1'b0);
    fe(20'hFFEE0, 8'h00, 1'b1);
    rd(20'hFFEFF, rm(20'hFFEFF), 1'b0);
    $display("decode test done");
    rd(20'hFFFFE, 8'h00, 1'b0);
    wr(20'hFFFFE, 8'hFF, 8'h01, 1'b0);
    rd(20'hFFFFE, 8'h01, 1'b0);
    rd(20'hF2000, 8'h00, 1'b1);
    wr(20'hFFFFE, 8'hFE, 8'hFE, 1'b0);
    rd(20'hFFFFE, 8'h01, 1'b0);
    wr(20'hFFFFE, 8'h00, 8'hFF, 1'b0);
    rd(20'hF2000, fl(20'hF2000), 1'b0);
    idle();
    boot_wr_protect = 1'b1;
    wr(20'h00FFF, 8'h11, 8'hFF, 1'b1);
    wr(20'h01000, 8'h11, 8'hFF, 1'b0);
    idle();
    boot_wr_protect = 1'b0;
    wr(20'h00000, 8'h11, 8'hFF, 1'b0);
    idle();
    $display("mirror select and protect test done");
    vec(1'b0, 6'd0);
    vec(1'b0, 6'd63);
    vec(1'b1, 6'd0);
    vec(1'b1, 6'd31);
    parity_dis_we = 1'b1;
    parity_dis_wdata = 1'b1;
    @(negedge sys_clk);
    parity_dis_we = 1'b0;
    chk("parity_disable", 1, ram_parity_reset_disable);
    wr(20'hFFFFE, 8'h01, 8'h01, 1'b0);
    idle();
    repeat (4) @(negedge sys_clk);
    do_reset(1'b1);
    rd(20'hFFFFE, 8'h00, 1'b0);
    idle();
    vec(1'b0, 6'd1);
    vec(1'b1, 6'd31);
    $display("boot swap test done");
    repeat (6) @(negedge sys_clk);
    chk("pending results", 0, exp_cpu.size() + exp_vec.size());
    complete_run();
  end
endmodule
`default_nettype wire
